// file: rtl/crs_map.svh
// register offsets, flag bit positions and address-map constants of the cpu register set
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// wishbone word offsets (byte address)
`define CRS_OFS_DATA0 6'h00
`define CRS_OFS_DATA1 6'h04
`define CRS_OFS_DATA2 6'h08
`define CRS_OFS_DATA3 6'h0c
`define CRS_OFS_ADDR0 6'h10
`define CRS_OFS_ADDR1 6'h14
`define CRS_OFS_FRAME 6'h18
`define CRS_OFS_VTB 6'h1c
`define CRS_OFS_PC 6'h20
`define CRS_OFS_USP 6'h24
`define CRS_OFS_ISP 6'h28
`define CRS_OFS_SB 6'h2c
`define CRS_OFS_FLG 6'h30
`define CRS_OFS_SP 6'h34
// flag bit positions
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_I 6
`define CRS_FLG_U 7
`define CRS_FLG_IPL_LO 8
`define CRS_FLG_IPL_HI 10
// software vectors that switch to the interrupt stack
`define CRS_SWI_USTK_MAX 6'h1f
// address map
`define CRS_SFR0_LO 20'h00000
`define CRS_SFR0_HI 20'h003ff
`define CRS_SFR1_LO 20'h0d000
`define CRS_SFR1_HI 20'h0d7ff
`define CRS_FVT_LO 20'hfffdc
`define CRS_FVT_HI 20'hfffff
`define CRS_RVT_SPAN 20'h00100
// reset values
`define CRS_FLG_RST 11'h000
`define CRS_W16_RST 16'h0000
`define CRS_W20_RST 20'h00000
`endif

// file: rtl/crs_pkg.sv
// types of the cpu register set
package crs_pkg;
  typedef struct packed {
    logic [15:0] d0;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] d3;
    logic [15:0] a0;
    logic [15:0] a1;
    logic [15:0] fb;
  } crs_bank_t;

  typedef enum logic [1:0] {
    CRS_BUS_IDLE = 2'b00,
    CRS_BUS_ACK = 2'b01
  } crs_bus_t;

  // one alu result with its flag sources
  typedef struct packed {
    logic valid;
    logic [15:0] result;
    logic carry;
    logic overflow;
    logic byte_op;
  } crs_alu_t;

  // interrupt acceptance request
  typedef struct packed {
    logic hw_req;
    logic maskable;
    logic [2:0] prio;
    logic swi;
    logic [5:0] swi_vec;
  } crs_irq_t;

  // register operand views
  typedef struct packed {
    logic [7:0] d0_upper;
    logic [7:0] d0_lower;
    logic [7:0] d1_upper;
    logic [7:0] d1_lower;
    logic [31:0] pair_low;
    logic [31:0] pair_high;
    logic [31:0] addr_pair;
    logic [15:0] frame_base;
    logic [15:0] static_base;
    logic [15:0] stack_ptr;
    logic [19:0] program_counter;
    logic [19:0] vector_table_base;
  } crs_view_t;

  typedef struct packed {
    crs_bank_t [1:0] bank;
    logic [19:0] vtb;
    logic [19:0] pc;
    logic [15:0] user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] sb;
    logic [10:0] processor_flags;
    crs_bus_t bus;
    logic [31:0] rdata;
    crs_view_t view;
    logic irq_take;
    logic sfr_hit;
    logic fvt_hit;
    logic rvt_hit;
  } crs_state_t;
endpackage

// file: rtl/crs_regset.sv
// cpu architectural register set with wishbone access, flag logic and address decode
// Functional notes
// - two banks each of four data, two address and one frame base register
// - data registers 16 bits; first two also as byte halves
// - pairs form 32-bit operands: third over first, fourth over second
// - two 16-bit address registers combine, second one upper
// - 16-bit frame base supplies frame-relative address base
// - 16-bit static base supplies static-relative address base
// - 20-bit vector table base holds relocatable table start
// - relocatable table spans 256 bytes from the table base
// - 20-bit program counter holds next instruction address
// - two 16-bit stack pointers; flag 0 interrupt, 1 user
// - stack flag clears on hardware interrupt or software vector 0 to 31
// - 11-bit flag register holds all flags and priority field
// - carry flag captures carry, borrow or shifted-out bit
// - zero flag set on zero result, else cleared
// - sign flag set on negative result, else cleared
// - bank flag selects bank 0 or bank 1
// - overflow flag follows arithmetic overflow
// - interrupt enable gates maskable requests, clears on acceptance
// - 3-bit priority; accept maskable requests only above it
// - decode peripheral register regions and fixed vector table
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"

module crs_regset (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // alu result and flag update
  input wire crs_pkg::crs_alu_t alu_i,
  // interrupt requests
  input wire crs_pkg::crs_irq_t irq_i,
  output logic irq_accept_o,
  // address decode
  input wire logic [19:0] probe_addr_i,
  output logic sfr_hit_o,
  output logic fixed_vector_hit_o,
  output logic reloc_vector_hit_o,
  // register views
  output crs_pkg::crs_view_t view_o,
  output logic [10:0] processor_flags_o
);
  import crs_pkg::*;

  crs_state_t s_q;
  crs_state_t s_d;
  logic bsel;
  logic acc;
  logic wr;
  logic [31:0] wm;
  logic [31:0] rd;
  logic [19:0] rvt_end;
  crs_bank_t cb;

  always_comb begin
    s_d = s_q;
    acc = 1'b0;
    wr = 1'b0;
    bsel = s_q.processor_flags[`CRS_FLG_B];
    cb = s_q.bank[bsel];
    wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    rd = 32'h0000_0000;
    rvt_end = s_q.vtb + `CRS_RVT_SPAN;

    // wishbone: ack one cycle after strobe, dropped the next cycle
    unique case (s_q.bus)
      CRS_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          acc = 1'b1;
          wr = wb_we_i;
          s_d.bus = CRS_BUS_ACK;
        end
      end
      CRS_BUS_ACK: begin
        s_d.bus = CRS_BUS_IDLE;
      end
    endcase

    // banked registers go to the bank the flag selects
    unique case (wb_adr_i)
      `CRS_OFS_DATA0: rd = {16'h0000, cb.d0};
      `CRS_OFS_DATA1: rd = {16'h0000, cb.d1};
      `CRS_OFS_DATA2: rd = {16'h0000, cb.d2};
      `CRS_OFS_DATA3: rd = {16'h0000, cb.d3};
      `CRS_OFS_ADDR0: rd = {16'h0000, cb.a0};
      `CRS_OFS_ADDR1: rd = {16'h0000, cb.a1};
      `CRS_OFS_FRAME: rd = {16'h0000, cb.fb};
      `CRS_OFS_VTB: rd = {12'h000, s_q.vtb};
      `CRS_OFS_PC: rd = {12'h000, s_q.pc};
      `CRS_OFS_USP: rd = {16'h0000, s_q.user_stack_pointer};
      `CRS_OFS_ISP: rd = {16'h0000, s_q.interrupt_stack_pointer};
      `CRS_OFS_SB: rd = {16'h0000, s_q.sb};
      `CRS_OFS_FLG: rd = {21'h000000, s_q.processor_flags};
      `CRS_OFS_SP: rd = {16'h0000, s_q.view.stack_ptr};
      default: rd = 32'h0000_0000;
    endcase
    if (acc) begin
      s_d.rdata = rd;
    end

    if (wr) begin
      unique case (wb_adr_i)
        `CRS_OFS_DATA0: cb.d0 = (cb.d0 & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_DATA1: cb.d1 = (cb.d1 & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_DATA2: cb.d2 = (cb.d2 & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_DATA3: cb.d3 = (cb.d3 & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_ADDR0: cb.a0 = (cb.a0 & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_ADDR1: cb.a1 = (cb.a1 & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_FRAME: cb.fb = (cb.fb & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_VTB: s_d.vtb = (s_q.vtb & ~wm[19:0]) | (wb_dat_i[19:0] & wm[19:0]);
        `CRS_OFS_PC: s_d.pc = (s_q.pc & ~wm[19:0]) | (wb_dat_i[19:0] & wm[19:0]);
        `CRS_OFS_USP: s_d.user_stack_pointer = (s_q.user_stack_pointer & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_ISP: s_d.interrupt_stack_pointer = (s_q.interrupt_stack_pointer & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        `CRS_OFS_SB: s_d.sb = (s_q.sb & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
        // reserved bits above the field are simply not stored
        `CRS_OFS_FLG: s_d.processor_flags = (s_q.processor_flags & ~wm[10:0]) | (wb_dat_i[10:0] & wm[10:0]);
        // the active-pointer alias writes whichever pointer the stack flag picks
        `CRS_OFS_SP: begin
          if (s_q.processor_flags[`CRS_FLG_U]) begin
            s_d.user_stack_pointer = (s_q.user_stack_pointer & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
          end else begin
            s_d.interrupt_stack_pointer = (s_q.interrupt_stack_pointer & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
          end
        end
        default: ;
      endcase
    end
    s_d.bank[bsel] = cb;

    // alu flags; a software flag write in the same cycle loses to hardware
    if (alu_i.valid) begin
      if (alu_i.byte_op) begin
        s_d.processor_flags[`CRS_FLG_Z] = (alu_i.result[7:0] == 8'h00);
        s_d.processor_flags[`CRS_FLG_S] = alu_i.result[7];
      end else begin
        s_d.processor_flags[`CRS_FLG_Z] = (alu_i.result == 16'h0000);
        s_d.processor_flags[`CRS_FLG_S] = alu_i.result[15];
      end
      s_d.processor_flags[`CRS_FLG_C] = alu_i.carry;
      s_d.processor_flags[`CRS_FLG_O] = alu_i.overflow;
    end

    // interrupt acceptance: maskable ones need enable and higher priority
    s_d.irq_take = 1'b0;
    if (irq_i.hw_req) begin
      if (!irq_i.maskable
          || (s_q.processor_flags[`CRS_FLG_I]
              && (irq_i.prio > s_q.processor_flags[`CRS_FLG_IPL_HI:`CRS_FLG_IPL_LO]))) begin
        s_d.irq_take = 1'b1;
        s_d.processor_flags[`CRS_FLG_I] = 1'b0;
        s_d.processor_flags[`CRS_FLG_U] = 1'b0;
      end
    end else if (irq_i.swi) begin
      s_d.irq_take = 1'b1;
      s_d.processor_flags[`CRS_FLG_I] = 1'b0;
      if (irq_i.swi_vec <= `CRS_SWI_USTK_MAX) begin
        s_d.processor_flags[`CRS_FLG_U] = 1'b0;
      end
    end

    // views are built from the next state; a bank change shows in the same cycle as the flag
    bsel = s_d.processor_flags[`CRS_FLG_B];
    cb = s_d.bank[bsel];
    s_d.view.d0_upper = cb.d0[15:8];
    s_d.view.d0_lower = cb.d0[7:0];
    s_d.view.d1_upper = cb.d1[15:8];
    s_d.view.d1_lower = cb.d1[7:0];
    s_d.view.pair_low = {cb.d2, cb.d0};
    s_d.view.pair_high = {cb.d3, cb.d1};
    s_d.view.addr_pair = {cb.a1, cb.a0};
    s_d.view.frame_base = cb.fb;
    s_d.view.static_base = s_d.sb;
    s_d.view.stack_ptr = s_d.processor_flags[`CRS_FLG_U] ? s_d.user_stack_pointer : s_d.interrupt_stack_pointer;
    s_d.view.program_counter = s_d.pc;
    s_d.view.vector_table_base = s_d.vtb;

    // address decode, registered
    s_d.sfr_hit = ((probe_addr_i >= `CRS_SFR0_LO) && (probe_addr_i <= `CRS_SFR0_HI))
                  || ((probe_addr_i >= `CRS_SFR1_LO) && (probe_addr_i <= `CRS_SFR1_HI));
    s_d.fvt_hit = (probe_addr_i >= `CRS_FVT_LO) && (probe_addr_i <= `CRS_FVT_HI);
    // a table placed at the very top wraps; the wrapped end covers that case
    if (rvt_end > s_q.vtb) begin
      s_d.rvt_hit = (probe_addr_i >= s_q.vtb) && (probe_addr_i < rvt_end);
    end else begin
      s_d.rvt_hit = (probe_addr_i >= s_q.vtb) || (probe_addr_i < rvt_end);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.processor_flags <= `CRS_FLG_RST;
      s_q.pc <= `CRS_W20_RST;
      s_q.vtb <= `CRS_W20_RST;
      s_q.user_stack_pointer <= `CRS_W16_RST;
      s_q.interrupt_stack_pointer <= `CRS_W16_RST;
      s_q.bus <= CRS_BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = (s_q.bus == CRS_BUS_ACK);
  assign wb_dat_o = s_q.rdata;
  assign irq_accept_o = s_q.irq_take;
  assign sfr_hit_o = s_q.sfr_hit;
  assign fixed_vector_hit_o = s_q.fvt_hit;
  assign reloc_vector_hit_o = s_q.rvt_hit;
  assign view_o = s_q.view;
  assign processor_flags_o = s_q.processor_flags;
endmodule // crs_regset
`default_nettype wire

// file: dv/crs_regset_checker.sv
// flag, interrupt and decode assertions for the cpu register set
`timescale 1ns/1ps
`default_nettype none
module crs_regset_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire crs_pkg::crs_alu_t alu_i,
  input wire crs_pkg::crs_irq_t irq_i,
  input wire logic irq_accept_o,
  input wire logic [19:0] probe_addr_i,
  input wire logic sfr_hit_o,
  input wire logic fixed_vector_hit_o,
  input wire logic [10:0] processor_flags_o
);
  import crs_pkg::*;
  logic z_w;
  logic s_w;
  logic hw_w;
  // byte operations judge zero and sign on the low byte only
  assign z_w = alu_i.byte_op ? alu_i.result[7:0] == 8'h00 : alu_i.result == 16'h0000;
  assign s_w = alu_i.byte_op ? alu_i.result[7] : alu_i.result[15];
  assign hw_w = irq_i.hw_req && irq_i.maskable && !irq_i.swi;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_CARRY: assert property (alu_i.valid |=> processor_flags_o[0] == $past(alu_i.carry))
    else $error("carry flag wrong");
  AST_ZERO: assert property (alu_i.valid |=> processor_flags_o[2] == $past(z_w))
    else $error("zero flag wrong");
  AST_SIGN: assert property (alu_i.valid |=> processor_flags_o[3] == $past(s_w))
    else $error("sign flag wrong");
  AST_OVF: assert property (alu_i.valid |=> processor_flags_o[5] == $past(alu_i.overflow))
    else $error("overflow flag wrong");
  AST_ACC_CLR: assert property (irq_accept_o |-> !processor_flags_o[6])
    else $error("enable flag kept on accept");
  AST_MASKED: assert property (hw_w && !processor_flags_o[6] |=> !irq_accept_o)
    else $error("masked request taken");
  AST_PRIO: assert property (hw_w && irq_i.prio <= processor_flags_o[10:8] |=> !irq_accept_o)
    else $error("low priority request taken");
  AST_HW_USTK: assert property (irq_i.hw_req && !irq_i.maskable |=> irq_accept_o && !processor_flags_o[7])
    else $error("stack flag kept on hardware request");
  AST_SFR: assert property (1'b1 |=> sfr_hit_o == $past(probe_addr_i <= 20'h003ff
    || (probe_addr_i >= 20'h0d000 && probe_addr_i <= 20'h0d7ff)))
    else $error("peripheral region decode wrong");
  AST_FVT: assert property (1'b1 |=> fixed_vector_hit_o == $past(probe_addr_i >= 20'hfffdc))
    else $error("fixed table decode wrong");
endmodule // crs_regset_checker
bind crs_regset crs_regset_checker chk (.clk_i, .rst_i, .alu_i, .irq_i, .irq_accept_o,
  .probe_addr_i, .sfr_hit_o, .fixed_vector_hit_o, .processor_flags_o);
`default_nettype wire

// file: dv/crs_regset_test.sv
// self-checking testbench for the cpu register set
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"
module crs_regset_test;
  import crs_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q, r;
  logic wb_ack_o, irq_accept_o, sfr_hit_o, fixed_vector_hit_o, reloc_vector_hit_o;
  logic [19:0] probe_addr_i = '0, b;
  logic [19:0] pa [12];
  crs_alu_t alu_i = '0;
  crs_irq_t irq_i = '0;
  crs_view_t view_o;
  logic [10:0] processor_flags_o;
  logic [15:0] v [7];
  logic [31:0] w [5];
  int error_cnt = 0, check_count = 0, seed = 32'h99bf700f;
  crs_regset uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .alu_i, .irq_i, .irq_accept_o, .probe_addr_i,
    .sfr_hit_o, .fixed_vector_hit_o, .reloc_vector_hit_o, .view_o, .processor_flags_o);
  always #5 clk_i = ~clk_i;
  function automatic logic [3:0] alu_exp(logic [31:0] x);
    return {x[18], x[16] ? x[7] : x[15], x[16] ? ~|x[7:0] : ~|x[15:0], x[17]};
  endfunction
  function automatic logic [2:0] hits(logic [19:0] p, logic [19:0] t);
    return {p <= 20'h003ff || (p >= 20'h0d000 && p <= 20'h0d7ff), p >= 20'hfffdc,
      20'(p - t) < 20'h00100};
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // request held until the edge that sees ack, released right after it
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    // sampled right after the edge, so ack and data are the values the edge saw
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      end_of_test();
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(e, q, n);
  endtask
  task automatic wf(input logic [10:0] f);
    wb(1'b1, `CRS_OFS_FLG, {21'h0, f}, 4'hf);
    repeat (2) @(negedge clk_i);
  endtask
  task automatic irq_rq(input crs_irq_t x, input logic [11:0] e);
    @(posedge clk_i);
    irq_i <= x;
    @(posedge clk_i);
    irq_i <= '0;
    @(negedge clk_i);
    chk({20'h0, e}, {20'h0, irq_accept_o, processor_flags_o}, "irq");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(32'h0, processor_flags_o, "flags after reset");
    for (int i = 0; i < 7; i++) begin
      r = $random(seed);
      v[i] = r[15:0];
      wb(1'b1, 6'(4 * i), r, 4'hf);
      rd(6'(4 * i), {16'h0, v[i]}, "bank0 reg");
    end
    repeat (2) @(negedge clk_i);
    chk({v[2], v[0]}, view_o.pair_low, "pair low");
    chk({v[3], v[1]}, view_o.pair_high, "pair high");
    chk({v[5], v[4]}, view_o.addr_pair, "addr pair");
    chk({v[1], v[0]}, {view_o.d1_upper, view_o.d1_lower, view_o.d0_upper, view_o.d0_lower},
      "halves");
    chk({16'h0, v[6]}, view_o.frame_base, "frame base");
    wf(11'h010);
    chk(32'h0, view_o.pair_low, "bank1 pair");
    wb(1'b1, 6'h00, ~r, 4'h1);
    rd(6'h00, {24'h0, ~r[7:0]}, "lane write");
    wf(11'h000);
    rd(6'h00, {16'h0, v[0]}, "bank0 kept");
    rd(6'h38, 32'h0, "unmapped");
    for (int i = 0; i < 5; i++) begin
      w[i] = $random(seed) & (i < 2 ? 32'hfffff : 32'hffff);
      wb(1'b1, 6'h1c + 6'(4 * i), ~w[i] ^ 32'hfff00000, 4'hf);
      wb(1'b1, 6'h1c + 6'(4 * i), w[i] | 32'hfff00000, 4'hf);
      rd(6'h1c + 6'(4 * i), w[i], "wide reg");
    end
    repeat (2) @(negedge clk_i);
    chk(w[0], {12'h0, view_o.vector_table_base}, "table base view");
    chk(w[1], {12'h0, view_o.program_counter}, "pc view");
    wf(11'h080);
    chk(w[2], view_o.stack_ptr, "user stack");
    wf(11'h000);
    chk(w[3], view_o.stack_ptr, "irq stack");
    rd(`CRS_OFS_SP, w[3], "active stack alias");
    chk(w[4], view_o.static_base, "static base");
    b = w[0][19:0];
    pa = '{20'h003ff, 20'h00400, 20'h0cfff, 20'h0d000, 20'h0d7ff, 20'h0d800, 20'hfffdb,
      20'hfffdc, b + 20'hff, b + 20'h100, 20'($random(seed)), 20'($random(seed))};
    foreach (pa[i]) begin
      @(posedge clk_i);
      probe_addr_i <= pa[i];
      @(posedge clk_i);
      @(negedge clk_i);
      chk(hits(pa[i], b), {sfr_hit_o, fixed_vector_hit_o, reloc_vector_hit_o}, "decode");
    end
    for (int i = 0; i < 40; i++) begin
      r = i == 0 ? 32'h0 : i == 1 ? 32'h00010100 : $random(seed);
      @(posedge clk_i);
      alu_i <= {1'b1, r[15:0], r[17], r[18], r[16]};
      @(posedge clk_i);
      alu_i.valid <= 1'b0;
      @(negedge clk_i);
      chk(alu_exp(r), {processor_flags_o[5], processor_flags_o[3:2], processor_flags_o[0]},
        "alu flags");
    end
    wf(11'h3c0);
    irq_rq({2'b11, 3'd3, 7'h0}, 12'h3c0);
    irq_rq({2'b11, 3'd5, 7'h0}, 12'hb00);
    wf(11'h380);
    irq_rq({2'b11, 3'd7, 7'h0}, 12'h380);
    wf(11'h080);
    irq_rq({5'h0, 1'b1, 6'd32}, 12'h880);
    irq_rq({5'h0, 1'b1, 6'd31}, 12'h800);
    wf(11'h0c0);
    irq_rq({2'b10, 10'h0}, 12'h800);
    end_of_test();
  end
endmodule // crs_regset_test
`default_nettype wire
